// >>> jdc_defs.svh
// register map, field positions, reset values and timing figures of the jack detect config block
`ifndef JDC_DEFS_SVH
`define JDC_DEFS_SVH

`define JDC_TIMING_IDX 6'h19
`define JDC_THRESH_IDX 6'h1A
`define JDC_STATUS_IDX 6'h20

`define JDC_TIMING_RST 8'h00
`define JDC_THRESH_RST 8'h00
`define JDC_TIMING_WMASK 8'hE6
`define JDC_THRESH_WMASK 8'h7E

`define JDC_RATE_LSB 6
`define JDC_WIDTH_BIT 5
`define JDC_PCLK_LSB 1
`define JDC_HOOKSEL_BIT 6
`define JDC_INSMIN_LSB 4
`define JDC_COUPLE_BIT 3
`define JDC_DBLCUR_BIT 2
`define JDC_EN_BIT 1

`define JDC_RESP_OKAY 2'h0
`define JDC_RESP_SLVERR 2'h2

`define JDC_CLK_HZ 25000000
`define JDC_RATE0_MHZ 500
`define JDC_RATE1_MHZ 1000
`define JDC_RATE2_MHZ 7500
`define JDC_RATE3_MHZ 15000
`define JDC_WIDTH0_MS 4
`define JDC_WIDTH1_MS 32
`define JDC_PCLK0_MS 1
`define JDC_PCLK1_MS 2
`define JDC_PCLK2_MS 4

`define JDC_MIC_LO_OHM 11'h320
`define JDC_HOOK_LO_AC_OHM 11'h140
`define JDC_HOOK_LO_DC_OHM 11'h096
`define JDC_HOOK_HI_OHM 11'h2A8
`define JDC_MIC_HI_AC_OHM 11'h546
`define JDC_MIC_HI_DC_OHM 11'h6D6
`define JDC_INS_150_OHM 11'h096
`define JDC_INS_100_OHM 11'h064
`define JDC_INS_50_OHM 11'h032

`endif

// >>> jdc_pkg.sv
// types shared by the jack detect config block
package jdc_pkg;
  `include "jdc_defs.svh"

  typedef enum logic [1:0] {
    JDC_IDLE = 2'h0,
    JDC_HIGH = 2'h1,
    JDC_LOW = 2'h3
  } jdc_eng_t;

  typedef struct packed {
    logic aw_got;
    logic [5:0] aw_idx;
    logic w_got;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] timing_cfg;
    logic [7:0] thresh_cfg;
    jdc_eng_t eng;
    logic [25:0] per_cnt;
    logic [16:0] clk_cnt;
    logic pulse;
    logic clk_tick;
    logic period_start;
  } jdc_state_t;

  typedef struct packed {
    logic [10:0] hook_max;
    logic [10:0] mic_min;
    logic [10:0] ins_min;
    logic ins_valid;
  } jdc_thr_state_t;
endpackage

// >>> jdc_threshold_map.sv
// maps comparator selections and coupling onto impedance limits
`timescale 1ns/1ps
module jdc_threshold_map import jdc_pkg::*; (
  input logic aclk,
  input logic aresetn,
  input logic hook_threshold_sel,
  input logic phone_coupling_sel,
  input logic [1:0] hook_insert_min_impedance_sel,
  input logic external_resistor_type_bit,
  output logic [10:0] hook_max_ohms,
  output logic [10:0] mic_min_ohms,
  output logic [10:0] insert_min_hook_ohms,
  output logic insert_min_valid
);
  jdc_thr_state_t s;
  jdc_thr_state_t n;

  always_comb begin
    n = s;
    if (!hook_threshold_sel) begin
      n.mic_min = `JDC_MIC_LO_OHM;
      n.hook_max = phone_coupling_sel ? `JDC_HOOK_LO_DC_OHM : `JDC_HOOK_LO_AC_OHM;
    end else begin
      n.hook_max = `JDC_HOOK_HI_OHM;
      n.mic_min = phone_coupling_sel ? `JDC_MIC_HI_DC_OHM : `JDC_MIC_HI_AC_OHM;
    end
    case (hook_insert_min_impedance_sel)
      2'h0: n.ins_min = `JDC_INS_150_OHM;
      2'h1: n.ins_min = `JDC_INS_100_OHM;
      2'h2: n.ins_min = `JDC_INS_50_OHM;
      default: n.ins_min = `JDC_INS_150_OHM;
    endcase
    // limit is meaningless for the other resistor type
    n.ins_valid = !external_resistor_type_bit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign hook_max_ohms = s.hook_max;
  assign mic_min_ohms = s.mic_min;
  assign insert_min_hook_ohms = s.ins_min;
  assign insert_min_valid = s.ins_valid;
endmodule

// >>> jdc_jack_detect_config_regs.sv
// jack detect configuration registers with probe pulse and period timing engine
//
// Behaviour
// - pulse repetition code 0..3 gives 0.5, 1, 7.5, 15 Hz.
// - pulse stays high 4 ms with width bit 0, 32 ms with 1.
// - detection clock period code gives 1, 2, 4 ms; code 3 reserved.
// - reserved bits read zero, ignore writes; software writes zero there.
// - hook threshold bit picks 800/320 ohm or 680/1350 ohm limits.
// - dc coupling moves low hook limit to 150, high mic to 1750.
// - insert hook minimum 150/100/50 ohm, only for resistor type zero.
// - coupling bit 0 means ac coupled, 1 means dc coupled.
// - current select bit 1 doubles the detection current.
// - detection runs only while the enable bit is one.
`timescale 1ns/1ps
module jdc_jack_detect_config_regs import jdc_pkg::*; #(
  parameter int unsigned RATE0_CYC =
    int'(64'(`JDC_CLK_HZ) * 64'd1000 / 64'(`JDC_RATE0_MHZ)),
  parameter int unsigned RATE1_CYC =
    int'(64'(`JDC_CLK_HZ) * 64'd1000 / 64'(`JDC_RATE1_MHZ)),
  parameter int unsigned RATE2_CYC =
    int'(64'(`JDC_CLK_HZ) * 64'd1000 / 64'(`JDC_RATE2_MHZ)),
  parameter int unsigned RATE3_CYC =
    int'(64'(`JDC_CLK_HZ) * 64'd1000 / 64'(`JDC_RATE3_MHZ)),
  parameter int unsigned WIDTH0_CYC = `JDC_CLK_HZ / 1000 * `JDC_WIDTH0_MS,
  parameter int unsigned WIDTH1_CYC = `JDC_CLK_HZ / 1000 * `JDC_WIDTH1_MS,
  parameter int unsigned PCLK0_CYC = `JDC_CLK_HZ / 1000 * `JDC_PCLK0_MS,
  parameter int unsigned PCLK1_CYC = `JDC_CLK_HZ / 1000 * `JDC_PCLK1_MS,
  parameter int unsigned PCLK2_CYC = `JDC_CLK_HZ / 1000 * `JDC_PCLK2_MS
) (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic external_resistor_type_bit,
  output logic probe_pulse,
  output logic probe_period_start,
  output logic probe_clk_tick,
  output logic detect_active,
  output logic phone_dc_coupled,
  output logic double_probe_current_en,
  output logic headset_probe_enable,
  output logic [10:0] hook_max_ohms,
  output logic [10:0] mic_min_ohms,
  output logic [10:0] insert_min_hook_ohms,
  output logic insert_min_valid
);
  localparam logic [25:0] RATE0 = 26'(RATE0_CYC);
  localparam logic [25:0] RATE1 = 26'(RATE1_CYC);
  localparam logic [25:0] RATE2 = 26'(RATE2_CYC);
  localparam logic [25:0] RATE3 = 26'(RATE3_CYC);
  localparam logic [25:0] WIDTH0 = 26'(WIDTH0_CYC);
  localparam logic [25:0] WIDTH1 = 26'(WIDTH1_CYC);
  localparam logic [16:0] PCLK0 = 17'(PCLK0_CYC);
  localparam logic [16:0] PCLK1 = 17'(PCLK1_CYC);
  localparam logic [16:0] PCLK2 = 17'(PCLK2_CYC);

  jdc_state_t s;
  jdc_state_t n;

  logic [1:0] rate_sel;
  logic width_sel;
  logic [1:0] pclk_sel;
  logic enable;
  logic [25:0] period_c;
  logic [25:0] width_c;
  logic [16:0] pclk_c;
  logic [25:0] per_inc;
  logic [7:0] status_c;

  assign rate_sel = s.timing_cfg[`JDC_RATE_LSB +: 2];
  assign width_sel = s.timing_cfg[`JDC_WIDTH_BIT];
  assign pclk_sel = s.timing_cfg[`JDC_PCLK_LSB +: 2];
  assign enable = s.thresh_cfg[`JDC_EN_BIT];

  always_comb begin
    case (rate_sel)
      2'h0: period_c = RATE0;
      2'h1: period_c = RATE1;
      2'h2: period_c = RATE2;
      default: period_c = RATE3;
    endcase
    width_c = width_sel ? WIDTH1 : WIDTH0;
    case (pclk_sel)
      2'h1: pclk_c = PCLK1;
      2'h2: pclk_c = PCLK2;
      // reserved code falls back to the shortest period
      default: pclk_c = PCLK0;
    endcase
  end

  assign per_inc = s.per_cnt + 26'h0000001;

  // reserved positions are forced to zero on readback
  assign status_c = {5'h00, insert_min_valid, (s.eng != JDC_IDLE), s.pulse};

  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;

  always_comb begin
    n = s;

    // write channel: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata[7:0];
      n.w_strb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_got && n.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `JDC_RESP_OKAY;
      case (n.aw_idx)
        `JDC_TIMING_IDX: begin
          if (n.w_strb0) begin
            n.timing_cfg = n.w_data & `JDC_TIMING_WMASK;
          end
        end
        `JDC_THRESH_IDX: begin
          if (n.w_strb0) begin
            n.thresh_cfg = n.w_data & `JDC_THRESH_WMASK;
          end
        end
        // status is read-only, a write there is simply dropped
        `JDC_STATUS_IDX: n.bresp = `JDC_RESP_OKAY;
        default: n.bresp = `JDC_RESP_SLVERR;
      endcase
    end

    // read channel
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = `JDC_RESP_OKAY;
      case (s_axi_araddr[7:2])
        `JDC_TIMING_IDX: n.rdata = s.timing_cfg;
        `JDC_THRESH_IDX: n.rdata = s.thresh_cfg;
        `JDC_STATUS_IDX: n.rdata = status_c;
        default: begin
          n.rdata = 8'h00;
          n.rresp = `JDC_RESP_SLVERR;
        end
      endcase
    end

    // probe timing engine
    n.clk_tick = 1'b0;
    n.period_start = 1'b0;
    if (!enable) begin
      n.eng = JDC_IDLE;
      n.per_cnt = '0;
      n.clk_cnt = '0;
      n.pulse = 1'b0;
    end else begin
      case (s.eng)
        JDC_IDLE: begin
          // fresh period on every enable
          n.eng = JDC_HIGH;
          n.per_cnt = '0;
          n.clk_cnt = '0;
          n.pulse = 1'b1;
          n.period_start = 1'b1;
        end
        JDC_HIGH, JDC_LOW: begin
          // >= keeps the counter bounded if the rate shrinks mid period
          if (per_inc >= period_c) begin
            n.eng = JDC_HIGH;
            n.per_cnt = '0;
            n.pulse = 1'b1;
            n.period_start = 1'b1;
          end else begin
            n.per_cnt = per_inc;
            if (per_inc >= width_c) begin
              n.eng = JDC_LOW;
              n.pulse = 1'b0;
            end
          end
          if (s.clk_cnt + 17'h00001 >= pclk_c) begin
            n.clk_cnt = '0;
            n.clk_tick = 1'b1;
          end else begin
            n.clk_cnt = s.clk_cnt + 17'h00001;
          end
        end
        default: begin
          n.eng = JDC_IDLE;
          n.per_cnt = '0;
          n.clk_cnt = '0;
          n.pulse = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.timing_cfg <= `JDC_TIMING_RST;
      s.thresh_cfg <= `JDC_THRESH_RST;
      s.eng <= JDC_IDLE;
      s.bresp <= `JDC_RESP_OKAY;
      s.rresp <= `JDC_RESP_OKAY;
    end else begin
      s <= n;
    end
  end

  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {24'h000000, s.rdata};

  assign probe_pulse = s.pulse;
  assign probe_period_start = s.period_start;
  assign probe_clk_tick = s.clk_tick;
  assign detect_active = (s.eng != JDC_IDLE);
  assign phone_dc_coupled = s.thresh_cfg[`JDC_COUPLE_BIT];
  assign double_probe_current_en = s.thresh_cfg[`JDC_DBLCUR_BIT];
  assign headset_probe_enable = enable;

  jdc_threshold_map u_thr (
    .aclk(aclk),
    .aresetn(aresetn),
    .hook_threshold_sel(s.thresh_cfg[`JDC_HOOKSEL_BIT]),
    .phone_coupling_sel(s.thresh_cfg[`JDC_COUPLE_BIT]),
    .hook_insert_min_impedance_sel(s.thresh_cfg[`JDC_INSMIN_LSB +: 2]),
    .external_resistor_type_bit(external_resistor_type_bit),
    .hook_max_ohms(hook_max_ohms),
    .mic_min_ohms(mic_min_ohms),
    .insert_min_hook_ohms(insert_min_hook_ohms),
    .insert_min_valid(insert_min_valid)
  );
endmodule

// >>> jdc_jack_detect_config_regs_assertions.sv
// port-level checks for the jack detect config block
`timescale 1ns/1ps
module jdc_cfg_checker #(
  parameter int unsigned WIDTH0_CYC = 8,
  parameter int unsigned WIDTH1_CYC = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic probe_pulse,
  input wire logic probe_period_start,
  input wire logic probe_clk_tick,
  input wire logic detect_active,
  input wire logic phone_dc_coupled,
  input wire logic headset_probe_enable,
  input wire logic [10:0] hook_max_ohms,
  input wire logic [10:0] mic_min_ohms
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [25:0] hi_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || !probe_pulse) begin
      hi_cnt_reg <= 26'h0;
    end else begin
      hi_cnt_reg <= hi_cnt_reg + 26'h1;
    end
  end
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  // thresholds lag the register by a clock, so coupling must be settled first
  a_mic_ac: assert property ($past(aresetn) && !phone_dc_coupled && $stable(phone_dc_coupled)
    && mic_min_ohms != 11'h320 |-> mic_min_ohms == 11'h546) else $error("ac mic limit");
  a_hook_dc: assert property ($past(aresetn) && phone_dc_coupled && $stable(phone_dc_coupled)
    && hook_max_ohms != 11'h2A8 |-> hook_max_ohms == 11'h096) else $error("dc hook limit");
  a_pulse_start: assert property ($rose(probe_pulse) |-> probe_period_start)
    else $error("pulse rose outside period start");
  a_pulse_width: assert property ($fell(probe_pulse) && headset_probe_enable |->
    hi_cnt_reg == WIDTH0_CYC || hi_cnt_reg == WIDTH1_CYC) else $error("pulse width");
  a_disable_idle: assert property (!headset_probe_enable ##1 !headset_probe_enable |->
    !probe_pulse && !detect_active) else $error("engine runs while disabled");
  a_enable_start: assert property ($rose(headset_probe_enable) |->
    ##[0:1] (probe_period_start && probe_pulse)) else $error("no restart on enable");
  a_tick_single: assert property (probe_clk_tick |=> !probe_clk_tick)
    else $error("tick longer than one cycle");
  c_pulse_end: cover property ($fell(probe_pulse));
  c_enable: cover property ($rose(headset_probe_enable));
  c_dc_hook: cover property (phone_dc_coupled && hook_max_ohms == 11'h096);
endmodule

// >>> jdc_headset_model.sv
// headset in the jack: resistor strap and probe pulse observer
`timescale 1ns/1ps
module jdc_headset_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic probe_pulse,
  input wire logic resistor_cfg,
  output logic external_resistor_type_bit,
  output logic [7:0] pulse_seen_reg
);
  logic last_reg;
  // strap registered so it never moves on the sampling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_reg <= 1'b0;
      pulse_seen_reg <= 8'h00;
      external_resistor_type_bit <= 1'b0;
    end else begin
      last_reg <= probe_pulse;
      external_resistor_type_bit <= resistor_cfg;
      if (probe_pulse && !last_reg) begin
        pulse_seen_reg <= pulse_seen_reg + 8'h01;
      end
    end
  end
endmodule

// >>> tb_jack_detect_config_regs.sv
// self-checking bench for the jack detect config block
`timescale 1ns/1ps
module tb_jack_detect_config_regs;
  localparam logic [7:0] TIM_A = 8'h19 << 2;
  localparam logic [7:0] THR_A = 8'h1A << 2;
  // shortened counts so every rate fits a short run
  localparam int unsigned RT0 = 200, RT1 = 100, RT2 = 60, RT3 = 40;
  localparam int unsigned W0 = 8, W1 = 20;
  localparam int unsigned PK0 = 5, PK1 = 7, PK2 = 11;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic resistor_cfg = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic external_resistor_type_bit, probe_pulse, probe_period_start, probe_clk_tick;
  logic detect_active, phone_dc_coupled, double_probe_current_en, headset_probe_enable;
  logic insert_min_valid;
  logic [10:0] hook_max_ohms, mic_min_ohms, insert_min_hook_ohms;
  logic [7:0] pulse_seen;
  int bad_count = 0;
  int checks = 0;
  always #20 aclk = ~aclk;
  jdc_jack_detect_config_regs #(.RATE0_CYC(RT0), .RATE1_CYC(RT1), .RATE2_CYC(RT2),
    .RATE3_CYC(RT3), .WIDTH0_CYC(W0), .WIDTH1_CYC(W1), .PCLK0_CYC(PK0), .PCLK1_CYC(PK1),
    .PCLK2_CYC(PK2)) jdc_jack_detect_config_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .external_resistor_type_bit(external_resistor_type_bit), .probe_pulse(probe_pulse),
    .probe_period_start(probe_period_start), .probe_clk_tick(probe_clk_tick),
    .detect_active(detect_active), .phone_dc_coupled(phone_dc_coupled),
    .double_probe_current_en(double_probe_current_en),
    .headset_probe_enable(headset_probe_enable), .hook_max_ohms(hook_max_ohms),
    .mic_min_ohms(mic_min_ohms), .insert_min_hook_ohms(insert_min_hook_ohms),
    .insert_min_valid(insert_min_valid));
  jdc_headset_model jdc_headset_model_inst (.aclk(aclk), .aresetn(aresetn),
    .probe_pulse(probe_pulse), .resistor_cfg(resistor_cfg),
    .external_resistor_type_bit(external_resistor_type_bit), .pulse_seen_reg(pulse_seen));
  task automatic summarize();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] eb = 2'h0);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        // bready stays high so back to back calls never reassign it in one step
        chk("bresp", 32'(s_axi_bresp), 32'(eb));
        break;
      end
    end
    if (n == 50) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", 32'(s_axi_rresp), 32'(er));
        break;
      end
    end
    if (n == 50) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic t_regs();
    rd(TIM_A, 32'h0, 2'h0);
    rd(8'h80, 32'h4, 2'h0);
    rd(8'h70, 32'h0, 2'h2);
    // strobe low: the write is answered but has no effect
    s_axi_wstrb <= 4'h0;
    wr(TIM_A, 8'hE6);
    s_axi_wstrb <= 4'hF;
    rd(TIM_A, 32'h0, 2'h0);
    // software keeps reserved bits at zero
    wr(TIM_A, 8'hE6);
    rd(TIM_A, 32'hE6, 2'h0);
    wr(THR_A, 8'h7C);
    rd(THR_A, 32'h7C, 2'h0);
    wr(8'h80, 8'h00, 2'h0);
    wr(8'h70, 8'h00, 2'h2);
    wr(TIM_A, 8'h00);
  endtask
  task automatic t_thresh();
    logic [31:0] hk [4] = '{32'h140, 32'h096, 32'h2A8, 32'h2A8};
    logic [31:0] mc [4] = '{32'h320, 32'h320, 32'h546, 32'h6D6};
    logic [31:0] ins [4] = '{32'h096, 32'h064, 32'h032, 32'h096};
    for (int i = 0; i < 4; i++) begin
      wr(THR_A, {1'b0, i[1], i[1:0], i[0], i[1], 2'b00});
      repeat (2) @(posedge aclk);
      chk("hook_max", 32'(hook_max_ohms), hk[i]);
      chk("mic_min", 32'(mic_min_ohms), mc[i]);
      chk("insert_min", 32'(insert_min_hook_ohms), ins[i]);
      chk("dc", 32'(phone_dc_coupled), 32'(i[0]));
      chk("dbl_cur", 32'(double_probe_current_en), 32'(i[1]));
    end
    chk("insert_valid", 32'(insert_min_valid), 32'h1);
    resistor_cfg <= 1'b1;
    repeat (5) @(posedge aclk);
    chk("insert_valid", 32'(insert_min_valid), 32'h0);
    resistor_cfg <= 1'b0;
  endtask
  task automatic t_pulse();
    int rt [4] = '{RT0, RT1, RT2, RT3};
    int pc [4] = '{PK0, PK1, PK2, PK0};
    int h, p, t1, t2, n;
    logic [7:0] seen;
    for (int r = 0; r < 4; r++) begin
      wr(TIM_A, {r[1:0], r[0], 2'b00, r[1:0], 1'b0});
      wr(THR_A, 8'h02);
      for (n = 0; n < 300 && !probe_period_start; n++) @(posedge aclk);
      h = 0;
      p = 0;
      t1 = -1;
      t2 = -1;
      // ticks are timed inside one period, never across a restart
      do begin
        if (probe_pulse) h++;
        if (probe_clk_tick && t1 >= 0 && t2 < 0) t2 = p;
        if (probe_clk_tick && t1 < 0) t1 = p;
        p++;
        @(posedge aclk);
      end while (!probe_period_start && p < 300);
      chk("high", 32'(h), r[0] ? 32'(W1) : 32'(W0));
      chk("period", 32'(p), 32'(rt[r]));
      chk("tick", 32'(t2 - t1), 32'(pc[r]));
      wr(THR_A, 8'h00);
      @(posedge aclk);
      seen = pulse_seen;
      repeat (30) @(posedge aclk);
      chk("pulse_off", 32'(probe_pulse), 32'h0);
      chk("no_pulses", 32'(pulse_seen), 32'(seen));
      chk("active", 32'(detect_active), 32'h0);
      chk("enable", 32'(headset_probe_enable), 32'h0);
    end
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_thresh();
    t_pulse();
    summarize();
  end
endmodule
bind jdc_jack_detect_config_regs jdc_cfg_checker #(.WIDTH0_CYC(WIDTH0_CYC),
  .WIDTH1_CYC(WIDTH1_CYC)) jdc_cfg_checker_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .probe_pulse(probe_pulse), .probe_period_start(probe_period_start),
  .probe_clk_tick(probe_clk_tick), .detect_active(detect_active),
  .phone_dc_coupled(phone_dc_coupled), .headset_probe_enable(headset_probe_enable),
  .hook_max_ohms(hook_max_ohms), .mic_min_ohms(mic_min_ohms));
